// [logic/i2c_rx_pkg.sv]
`default_nettype none
package i2c_rx_pkg;

  localparam int unsigned BYTE_W         = 8;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0]  BIT_CNT_RESET  = 4'h0;
  localparam logic [7:0]  OWN_ADDR_RESET = 8'h00;
  localparam logic [7:0]  MASK_RESET     = 8'hFF;
  localparam logic [7:0]  RX_BUF_RESET   = 8'h00;
  localparam logic [4:0]  TENBIT_PREFIX  = 5'h1E;
  localparam int unsigned TENBIT_HI_POS  = 2;
  localparam int unsigned TENBIT_LO_POS  = 1;
  localparam int unsigned RX_DEPTH       = 2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_HOLD,
    ST_ACK
  } rx_state_e;

  typedef enum logic [1:0] {
    KIND_ADDR_FIRST,
    KIND_ADDR_LOW,
    KIND_DATA
  } byte_kind_e;

endpackage
`default_nettype wire

// [logic/byte_stream_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if #(
  parameter int unsigned WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (
    output valid,
    output data,
    input  ready
  );

  modport snk (
    input  valid,
    input  data,
    output ready
  );
endinterface
`default_nettype wire

// [logic/rx_buffer.sv]
`timescale 1ns/1ps
`default_nettype none
module rx_buffer #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic   clk,
  input  wire logic   rst_b,
  input  wire logic   ce,
  byte_stream_if.snk  fill,
  byte_stream_if.src  drain
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic             do_wr;
  logic             do_rd;

  // Ready only reflects free room, so the writer sees a true full
  assign fill.ready  = (count_q != CW'(DEPTH));
  assign drain.valid = (count_q != '0);
  assign drain.data  = mem_q[rd_ptr_q];
  assign do_wr       = fill.valid & fill.ready;
  assign do_rd       = drain.valid & drain.ready;

  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  always_ff @(posedge clk) begin
    if (ce && do_wr) begin
      mem_q[wr_ptr_q] <= fill.data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (ce) begin
      if (do_wr) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (do_rd) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
      if (do_wr && !do_rd) begin
        count_q <= CW'(count_q + 1'b1);
      end else if (do_rd && !do_wr) begin
        count_q <= CW'(count_q - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

// [logic/i2c_client_receiver.sv]
// Functional notes
// - Start sets start-seen, event if enabled
// - Matching 7-bit write address gets ACK, event
// - Reading receive buffer clears buffer-full flag unless a byte is queued
// - Stretch enable holds SCL until release bit
// - Each data byte after match, queue not full: ACK, event
// - Stop sets stop-seen, receiver goes idle
// - Address hold: eighth fall, event, clear release
// - Data hold: eighth fall, event, clear release
// - Ack-time status shows event before ACK slot
// - Hold modes: ACK level from select bit
// - Hold modes: event at ninth fall after ACK
// - Stretch plus hold: also stretch after ACK
// - Stop without enable only sets stop-seen
// - 10-bit high match: update flag, ACK, event
// - Update flag holds SCL until address write
// - 10-bit low match: update flag, ACK, event
// - Low mismatch: event, update flag, no buffer-full
// - 10-bit stretch: clear release after data ACK
// - 10-bit holds behave exactly as 7-bit
// - 7-bit compare ignores own-address LSB, needs received LSB 0
// - 10-bit high byte is 11110,A9,A8,0
// - Mask zero bits are don't-care, reset ones
// - Overflow on address: NACK, overflow flag
`timescale 1ns/1ps
`default_nettype none
module i2c_client_receiver #(
  parameter int unsigned RX_DEPTH = i2c_rx_pkg::RX_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       ten_bit_mode,
  input  wire logic       start_irq_enable,
  input  wire logic       stop_irq_enable,
  input  wire logic       stretch_enable,
  input  wire logic       address_hold_enable,
  input  wire logic       data_hold_enable,
  input  wire logic       ack_value_select,
  input  wire logic       buffer_override_enable,
  input  wire logic       event_clear,
  input  wire logic       overflow_clear,
  input  wire logic       clock_release_set,
  input  wire logic       receive_buffer_read,
  input  wire logic       own_address_write,
  input  wire logic [7:0] own_address_wdata,
  input  wire logic       address_mask_write,
  input  wire logic [7:0] address_mask_wdata,
  output logic [7:0]      receive_buffer,
  output logic            buffer_full_flag,
  output logic            serial_event_flag,
  output logic            start_seen,
  output logic            stop_seen,
  output logic            ack_time_status,
  output logic            update_address_flag,
  output logic            receive_overflow_flag,
  output logic            clock_release_bit,
  output logic [7:0]      own_address_register,
  output logic [7:0]      address_mask_register
);

  byte_stream_if #(.WIDTH(i2c_rx_pkg::BYTE_W)) fill_if ();
  byte_stream_if #(.WIDTH(i2c_rx_pkg::BYTE_W)) drain_if ();

  rx_buffer #(
    .WIDTH (i2c_rx_pkg::BYTE_W),
    .DEPTH (RX_DEPTH)
  ) u_rx_buffer (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .fill  (fill_if.snk),
    .drain (drain_if.src)
  );

  logic                   scl_m_q;
  logic                   scl_s_q;
  logic                   scl_p_q;
  logic                   sda_m_q;
  logic                   sda_s_q;
  logic                   sda_p_q;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_det;
  logic                   stop_det;
  i2c_rx_pkg::rx_state_e  state_q;
  i2c_rx_pkg::byte_kind_e kind_q;
  logic [7:0]             shift_q;
  logic [3:0]             bit_cnt_q;
  logic                   nack_q;
  logic                   byte_done;
  logic                   ack_end;
  logic                   addr_match;
  logic                   hold_mode;
  logic                   overflow_now;
  logic                   low_miss;
  logic                   push;
  logic                   ack_nack;
  logic                   event_set;
  logic                   hold_scl;

  // Masked compare: a zero mask bit makes that bit don't-care
  function automatic logic masked_equal(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic [7:0] m);
    masked_equal = (((a ^ b) & m) == 8'h00);
  endfunction

  // Pins cross into the clk domain; the first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce) begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  assign byte_done = (state_q == i2c_rx_pkg::ST_SHIFT) && scl_fall && (bit_cnt_q == i2c_rx_pkg::BITS_PER_BYTE);
  assign ack_end   = (state_q == i2c_rx_pkg::ST_ACK) && scl_fall;

  // Address and data classification at the eighth falling edge
  always_comb begin
    addr_match = 1'b0;
    hold_mode  = address_hold_enable;
    unique case (kind_q)
      i2c_rx_pkg::KIND_ADDR_FIRST: begin
        if (ten_bit_mode) begin
          addr_match = (shift_q[7:3] == i2c_rx_pkg::TENBIT_PREFIX) &&
                       (shift_q[2:1] == own_address_register[i2c_rx_pkg::TENBIT_HI_POS:i2c_rx_pkg::TENBIT_LO_POS]) &&
                       !shift_q[0];
        end else begin
          addr_match = masked_equal({shift_q[7:1], 1'b0}, {own_address_register[7:1], 1'b0},
                                    {address_mask_register[7:1], 1'b0}) && !shift_q[0];
        end
      end
      i2c_rx_pkg::KIND_ADDR_LOW: begin
        addr_match = masked_equal(shift_q, own_address_register, address_mask_register);
      end
      i2c_rx_pkg::KIND_DATA: begin
        addr_match = 1'b1;
        hold_mode  = data_hold_enable;
      end
    endcase
  end

  // No room left in the byte path counts as overflow
  assign overflow_now = !fill_if.ready;
  assign low_miss     = byte_done && (kind_q == i2c_rx_pkg::KIND_ADDR_LOW) && !addr_match;
  assign push         = byte_done && addr_match && fill_if.ready;
  assign ack_nack     = overflow_now && !buffer_override_enable;

  assign fill_if.valid  = push;
  assign fill_if.data   = shift_q;
  assign drain_if.ready = !buffer_full_flag || receive_buffer_read;

  assign event_set = (start_det && start_irq_enable) ||
                     (stop_det && stop_irq_enable) ||
                     (byte_done && addr_match && hold_mode) ||
                     low_miss ||
                     (ack_end && !nack_q);

  // Shift register, MSB first, sampled on SCL rising edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q   <= 8'h00;
      bit_cnt_q <= i2c_rx_pkg::BIT_CNT_RESET;
    end else if (ce) begin
      if (start_det || ack_end) begin
        bit_cnt_q <= i2c_rx_pkg::BIT_CNT_RESET;
      end else if (state_q == i2c_rx_pkg::ST_SHIFT && scl_rise && bit_cnt_q != i2c_rx_pkg::BITS_PER_BYTE) begin
        shift_q   <= {shift_q[6:0], sda_s_q};
        bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
      end
    end
  end

  // Byte sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= i2c_rx_pkg::ST_IDLE;
      kind_q  <= i2c_rx_pkg::KIND_ADDR_FIRST;
      nack_q  <= 1'b0;
    end else if (ce) begin
      if (stop_det) begin
        state_q <= i2c_rx_pkg::ST_IDLE;
      end else if (start_det) begin
        state_q <= i2c_rx_pkg::ST_SHIFT;
        kind_q  <= i2c_rx_pkg::KIND_ADDR_FIRST;
      end else begin
        unique case (state_q)
          i2c_rx_pkg::ST_IDLE: begin
          end
          i2c_rx_pkg::ST_SHIFT: begin
            if (byte_done) begin
              if (!addr_match) begin
                state_q <= i2c_rx_pkg::ST_IDLE;
              end else if (hold_mode) begin
                state_q <= i2c_rx_pkg::ST_HOLD;
              end else begin
                state_q <= i2c_rx_pkg::ST_ACK;
                nack_q  <= ack_nack;
              end
            end
          end
          i2c_rx_pkg::ST_HOLD: begin
            if (clock_release_bit) begin
              state_q <= i2c_rx_pkg::ST_ACK;
              nack_q  <= ack_value_select;
            end
          end
          i2c_rx_pkg::ST_ACK: begin
            if (ack_end) begin
              if (nack_q) begin
                state_q <= i2c_rx_pkg::ST_IDLE;
              end else begin
                state_q <= i2c_rx_pkg::ST_SHIFT;
                if (kind_q == i2c_rx_pkg::KIND_ADDR_FIRST && ten_bit_mode) begin
                  kind_q <= i2c_rx_pkg::KIND_ADDR_LOW;
                end else begin
                  kind_q <= i2c_rx_pkg::KIND_DATA;
                end
              end
            end
          end
        endcase
      end
    end
  end

  // Software-facing flags; a hardware set wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_event_flag     <= 1'b0;
      receive_overflow_flag <= 1'b0;
      ack_time_status       <= 1'b0;
    end else if (ce) begin
      serial_event_flag     <= event_set || (serial_event_flag && !event_clear);
      receive_overflow_flag <= (byte_done && addr_match && overflow_now && !buffer_override_enable) ||
                               (receive_overflow_flag && !overflow_clear);
      if (byte_done && addr_match && hold_mode) begin
        ack_time_status <= 1'b1;
      end else if (ack_end || start_det || stop_det) begin
        ack_time_status <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_seen <= 1'b0;
      stop_seen  <= 1'b0;
    end else if (ce) begin
      if (start_det) begin
        start_seen <= 1'b1;
        stop_seen  <= 1'b0;
      end else if (stop_det) begin
        stop_seen  <= 1'b1;
        start_seen <= 1'b0;
      end
    end
  end

  // Release bit: software set wins so a release is never swallowed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clock_release_bit <= 1'b1;
    end else if (ce) begin
      if (clock_release_set) begin
        clock_release_bit <= 1'b1;
      end else if (byte_done && addr_match && hold_mode) begin
        clock_release_bit <= 1'b0;
      end else if (ack_end && !nack_q && stretch_enable) begin
        clock_release_bit <= 1'b0;
      end
    end
  end

  // Update-address flag; set wins over the clearing address write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      update_address_flag <= 1'b0;
    end else if (ce) begin
      if ((ack_end && !nack_q && ten_bit_mode && kind_q != i2c_rx_pkg::KIND_DATA) || low_miss) begin
        update_address_flag <= 1'b1;
      end else if (own_address_write) begin
        update_address_flag <= 1'b0;
      end
    end
  end

  // Software is trusted to write the address only outside the ACK sequence
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      own_address_register  <= i2c_rx_pkg::OWN_ADDR_RESET;
      address_mask_register <= i2c_rx_pkg::MASK_RESET;
    end else if (ce) begin
      if (own_address_write) begin
        own_address_register <= own_address_wdata;
      end
      if (address_mask_write) begin
        address_mask_register <= address_mask_wdata;
      end
    end
  end

  // Receive buffer drains the queue only once software emptied it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      receive_buffer   <= i2c_rx_pkg::RX_BUF_RESET;
      buffer_full_flag <= 1'b0;
    end else if (ce) begin
      if (drain_if.valid && drain_if.ready) begin
        receive_buffer   <= drain_if.data;
        buffer_full_flag <= 1'b1;
      end else if (receive_buffer_read) begin
        buffer_full_flag <= 1'b0;
      end
    end
  end

  // SCL is only grabbed once already low, so the host's edge is never cut short
  assign hold_scl = !clock_release_bit || update_address_flag;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
    end else if (ce) begin
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
      scl_oe <= hold_scl && (!scl_s_q || scl_oe);
      if (ack_end || start_det || stop_det) begin
        sda_oe <= 1'b0;
      end else if (state_q == i2c_rx_pkg::ST_SHIFT && byte_done && addr_match && !hold_mode) begin
        sda_oe <= !ack_nack;
      end else if (state_q == i2c_rx_pkg::ST_HOLD && clock_release_bit) begin
        sda_oe <= !ack_value_select;
      end
    end
  end

endmodule
`default_nettype wire

// [sim/i2c_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input  wire logic scl_w,
  input  wire logic sda_w,
  output var logic  scl_h,
  output var logic  sda_h
);
  // SCL waits that ran out; the bench counts one mismatch if any occurred
  int stalls = 0;

  initial begin
    scl_h = 1'h1;
    sda_h = 1'h1;
  end

  // Long low phase so the client can grab SCL before the next rise
  task automatic pulse(output logic s);
    int n;
    n = 0;
    #400 scl_h = 1'h1;
    #50;
    while (scl_w !== 1'h1 && n < 5000) begin
      #50 n++;
    end
    if (n == 5000)
      stalls++;
    #50 s = sda_w;
    #100 scl_h = 1'h0;
    #200;
  endtask

  task automatic start;
    sda_h = 1'h1;
    #200 scl_h = 1'h1;
    #300 sda_h = 1'h0;
    #300 scl_h = 1'h0;
    #200;
  endtask

  task automatic stop;
    sda_h = 1'h0;
    #300 scl_h = 1'h1;
    #300 sda_h = 1'h1;
    #300;
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_h = b[i];
      pulse(s);
    end
    sda_h = 1'h1;
    pulse(s);
    ack = ~s;
  endtask
endmodule
`default_nettype wire

// [sim/i2c_client_receiver_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_rx_assertions (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       ce,
  input wire logic       scl_o,
  input wire logic       scl_oe,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       start_irq_enable,
  input wire logic       stop_irq_enable,
  input wire logic       ack_value_select,
  input wire logic       receive_buffer_read,
  input wire logic [7:0] receive_buffer,
  input wire logic       buffer_full_flag,
  input wire logic       serial_event_flag,
  input wire logic       start_seen,
  input wire logic       stop_seen,
  input wire logic       ack_time_status,
  input wire logic       update_address_flag,
  input wire logic       clock_release_bit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_open_drain; scl_o == 1'h0 && sda_o == 1'h0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  property p_start_event; $rose(start_seen) && start_irq_enable |-> ##[0:2] serial_event_flag; endproperty
  a_start_event: assert property (p_start_event) else $error("no event on start");
  property p_stop_excl; stop_seen |-> !start_seen; endproperty
  a_stop_excl: assert property (p_stop_excl) else $error("start and stop both seen");
  property p_stop_quiet;
    $rose(stop_seen) && !stop_irq_enable && !$past(serial_event_flag) |-> !serial_event_flag [*3];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("event on masked stop");
  property p_read_clears; ce && receive_buffer_read |=> !buffer_full_flag || $changed(receive_buffer); endproperty
  a_read_clears: assert property (p_read_clears) else $error("read kept buffer full");
  property p_hold_stretch; $fell(clock_release_bit) |-> ##[1:8] scl_oe; endproperty
  a_hold_stretch: assert property (p_hold_stretch) else $error("clock not held");
  property p_release; $rose(clock_release_bit) && !update_address_flag |-> ##[1:3] !scl_oe; endproperty
  a_release: assert property (p_release) else $error("clock not released");
  property p_ua_hold; $rose(update_address_flag) |-> ##[1:8] scl_oe; endproperty
  a_ua_hold: assert property (p_ua_hold) else $error("clock not held for address");
  property p_ack_time; $rose(ack_time_status) |-> ##[0:1] (serial_event_flag && !clock_release_bit); endproperty
  a_ack_time: assert property (p_ack_time) else $error("ack time without hold event");
  property p_ack_level; $rose(sda_oe) && ack_time_status |-> !ack_value_select; endproperty
  a_ack_level: assert property (p_ack_level) else $error("ack sent against select");
  property p_ack_go; $rose(clock_release_bit) && ack_time_status && !ack_value_select |-> ##[1:3] sda_oe; endproperty
  a_ack_go: assert property (p_ack_go) else $error("ack missing after release");

  cover property ($rose(ack_time_status));
  cover property ($rose(update_address_flag));
  cover property ($fell(clock_release_bit) ##[1:8] scl_oe);
endmodule

bind i2c_client_receiver i2c_rx_assertions u_i2c_rx_assertions (
  .clk, .rst_b, .ce, .scl_o, .scl_oe, .sda_o, .sda_oe, .start_irq_enable, .stop_irq_enable,
  .ack_value_select, .receive_buffer_read, .receive_buffer, .buffer_full_flag, .serial_event_flag,
  .start_seen, .stop_seen, .ack_time_status, .update_address_flag, .clock_release_bit);
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk = 1'h0;
  logic       rst_b = 1'h0;
  logic       ten_bit_mode, start_irq_enable, stretch_enable, address_hold_enable, data_hold_enable;
  logic       ack_value_select, own_address_write, address_mask_write, scl_o, scl_oe, sda_o, sda_oe;
  logic       scl_h, sda_h, buffer_full_flag, serial_event_flag, start_seen, stop_seen, ack_time_status;
  logic       update_address_flag, receive_overflow_flag, clock_release_bit, ack, stop_irq_enable;
  logic [3:0] sw;
  logic [7:0] own_address_wdata, address_mask_wdata, receive_buffer, own_address_register;
  logic [7:0] address_mask_register;
  logic [7:0] ovf [4] = '{8'hA0, 8'h11, 8'h22, 8'h33};
  int         fails = 0;
  int         check_count = 0;
  wire logic  scl_i = scl_h & ~(scl_oe & ~scl_o);
  wire logic  sda_i = sda_h & ~(sda_oe & ~sda_o);

  always #50 clk = ~clk;

  i2c_client_receiver u_i2c_client_receiver (
    .clk, .rst_b, .ce(1'h1), .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .ten_bit_mode,
    .start_irq_enable, .stop_irq_enable, .stretch_enable, .address_hold_enable, .data_hold_enable,
    .ack_value_select, .buffer_override_enable(1'h0), .event_clear(sw[0]), .overflow_clear(sw[1]),
    .clock_release_set(sw[2]), .receive_buffer_read(sw[3]), .own_address_write, .own_address_wdata,
    .address_mask_write, .address_mask_wdata, .receive_buffer, .buffer_full_flag, .serial_event_flag,
    .start_seen, .stop_seen, .ack_time_status, .update_address_flag, .receive_overflow_flag,
    .clock_release_bit, .own_address_register, .address_mask_register);

  i2c_host_model u_i2c_host_model (.scl_w(scl_i), .sda_w(sda_i), .scl_h, .sda_h);

  task automatic summarize;
    chk("host_scl_stalls", 8'h00, 8'(u_i2c_host_model.stalls));
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask

  task automatic strobe(input int k);
    @(posedge clk) #1 sw[k] = 1'h1;
    @(posedge clk) #1 sw[k] = 1'h0;
  endtask

  task automatic sw_ack;
    strobe(0);
    strobe(3);
  endtask

  task automatic rel;
    if (clock_release_bit !== 1'h1)
      strobe(2);
  endtask

  task automatic set_addr(input logic [7:0] a);
    @(posedge clk) #1 own_address_wdata = a;
    own_address_write = 1'h1;
    @(posedge clk) #1 own_address_write = 1'h0;
  endtask

  task automatic byte_ok(input logic [7:0] b, input logic exp_ack);
    u_i2c_host_model.send(b, ack);
    repeat (4) @(posedge clk);
    #1 chk("ack", exp_ack, ack);
  endtask

  // Software decides in the held slot, then releases SCL
  task automatic hold_byte(input logic [7:0] b, input logic exp_ack);
    int n;
    fork
      u_i2c_host_model.send(b, ack);
      begin
        n = 0;
        while (serial_event_flag !== 1'h1 && n < 300) begin
          @(posedge clk) #1 n++;
        end
        chk("ack_time_status", 1'h1, ack_time_status);
        chk("clock_release_bit", 1'h0, clock_release_bit);
        sw_ack;
        strobe(2);
      end
    join
    repeat (4) @(posedge clk);
    #1 chk("ack", exp_ack, ack);
    chk("serial_event_flag", exp_ack, serial_event_flag);
    chk("ack_time_status", 1'h0, ack_time_status);
    if (exp_ack)
      chk("clock_release_bit", 1'h0, clock_release_bit);
    strobe(0);
    rel;
  endtask

  initial begin
    #2_000_000;
    fails++;
    summarize;
  end

  initial begin
    {ten_bit_mode, stretch_enable, address_hold_enable, data_hold_enable, ack_value_select, sw} = '0;
    {stop_irq_enable, own_address_write, address_mask_write, own_address_wdata, address_mask_wdata} = '0;
    start_irq_enable = 1'h1;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'h1;
    chk("address_mask_register", 8'hFF, address_mask_register);
    set_addr(8'hA1);
    chk("own_address_register", 8'hA1, own_address_register);
    u_i2c_host_model.start();
    repeat (4) @(posedge clk);
    chk("start_seen", 1'h1, start_seen);
    chk("serial_event_flag", 1'h1, serial_event_flag);
    strobe(0);
    byte_ok(8'hA0, 1'h1);
    chk("receive_buffer", 8'hA0, receive_buffer);
    chk("serial_event_flag", 1'h1, serial_event_flag);
    sw_ack;
    chk("buffer_full_flag", 1'h0, buffer_full_flag);
    byte_ok(8'h5A, 1'h1);
    chk("receive_buffer", 8'h5A, receive_buffer);
    chk("serial_event_flag", 1'h1, serial_event_flag);
    sw_ack;
    u_i2c_host_model.stop();
    repeat (4) @(posedge clk);
    chk("stop_seen", 1'h1, stop_seen);
    chk("serial_event_flag", 1'h0, serial_event_flag);
    // Foreign address ignored until the mask frees bit 1
    for (int m = 0; m < 2; m++) begin
      u_i2c_host_model.start();
      strobe(0);
      byte_ok(8'hA2, m[0]);
      chk("serial_event_flag", m[0], serial_event_flag);
      sw_ack;
      u_i2c_host_model.stop();
      @(posedge clk) #1 address_mask_wdata = 8'hFD;
      address_mask_write = 1'h1;
      @(posedge clk) #1 address_mask_write = 1'h0;
    end
    u_i2c_host_model.start();
    strobe(0);
    for (int i = 0; i < 4; i++)
      byte_ok(ovf[i], i < 3);
    chk("receive_overflow_flag", 1'h1, receive_overflow_flag);
    u_i2c_host_model.stop();
    for (int i = 0; i < 3; i++) begin
      chk("receive_buffer", ovf[i], receive_buffer);
      strobe(3);
      repeat (2) @(posedge clk);
    end
    chk("buffer_full_flag", 1'h0, buffer_full_flag);
    strobe(1);
    chk("receive_overflow_flag", 1'h0, receive_overflow_flag);
    @(posedge clk) #1 {stretch_enable, address_hold_enable, data_hold_enable} = 3'h7;
    u_i2c_host_model.start();
    strobe(0);
    hold_byte(8'hA0, 1'h1);
    hold_byte(8'h77, 1'h1);
    @(posedge clk) #1 ack_value_select = 1'h1;
    hold_byte(8'h88, 1'h0);
    u_i2c_host_model.stop();
    @(posedge clk) #1 {ten_bit_mode, address_hold_enable, data_hold_enable, ack_value_select} = 4'h8;
    // Second pass sends a wrong low byte
    for (int k = 0; k < 2; k++) begin
      set_addr(8'hF2);
      u_i2c_host_model.start();
      strobe(0);
      byte_ok(8'hF2, 1'h1);
      chk("update_address_flag", 1'h1, update_address_flag);
      chk("serial_event_flag", 1'h1, serial_event_flag);
      sw_ack;
      set_addr(8'h34);
      rel;
      // A low-byte miss holds SCL by the update flag until the address is rewritten
      fork
        byte_ok({7'h1A, k[0]}, !k[0]);
        if (k == 1) begin
          while (update_address_flag !== 1'h1) @(posedge clk) #1;
          chk("update_address_flag", 1'h1, update_address_flag);
          set_addr(8'hF2);
        end
      join
      chk("update_address_flag", !k[0], update_address_flag);
      chk("serial_event_flag", 1'h1, serial_event_flag);
      chk("buffer_full_flag", !k[0], buffer_full_flag);
      if (k == 1)
        chk("clock_release_bit", 1'h1, clock_release_bit);
      sw_ack;
      set_addr(8'hF2);
      rel;
      if (k == 0) begin
        byte_ok(8'h9C, 1'h1);
        chk("clock_release_bit", 1'h0, clock_release_bit);
        sw_ack;
        rel;
      end
      u_i2c_host_model.stop();
    end
    @(posedge clk) #1 stop_irq_enable = 1'h1;
    u_i2c_host_model.start();
    strobe(0);
    u_i2c_host_model.stop();
    repeat (4) @(posedge clk);
    #1 chk("serial_event_flag", 1'h1, serial_event_flag);
    summarize;
  end
endmodule
`default_nettype wire
